// ---- tdc_defines.vh ----
// Constants for the ten-bit down counter with PWM output.
// Assumes inclusion by the counter top and its prescaler only.
`ifndef TDC_DEFINES_VH
`define TDC_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TDC_ADDR_COUNT 4'h0
`define TDC_ADDR_CTRL1 4'h4
`define TDC_ADDR_CTRL2 4'h8
`define TDC_ADDR_DUTY 4'hC
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TDC_C1_RUN 0
`define TDC_C1_RELOAD 1
`define TDC_C1_ONESHOT 2
`define TDC_C1_ACTLOW 6
`define TDC_C1_PINEN 7
`define TDC_C2_RATE_HI 2
`define TDC_C2_RATE_LO 0
`define TDC_C2_PSDIS_N 3
`define TDC_C2_EDGE 4
`define TDC_C2_SRC 5
`define TDC_C2_HIGH_HI 5
`define TDC_C2_HIGH_LO 4
`define TDC_DUTY_HIGH_HI 9
`define TDC_DUTY_HIGH_LO 8
// ----------------------------------------
// Reset values, fixed counts and bus response codes
// ----------------------------------------
`define TDC_CTRL1_RST 8'h00
`define TDC_CTRL2_RST 6'h3F
`define TDC_FULL_COUNT 10'h3FF
`define TDC_ZERO_COUNT 10'h000
`define TDC_RESP_OKAY 2'b00
`define TDC_RESP_SLVERR 2'b10
`endif

// ---- tdc_prescaler.v ----
// Power-of-two prescaler producing a one-cycle tick enable.
// Assumes tick_in is a one-cycle pulse on aclk.
`include "tdc_defines.vh"
module tdc_prescaler #(
	parameter WIDTH = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire tick_in,
	input wire bypass,
	input wire [2:0] ratio,
	output reg tick_out
);
	reg [WIDTH-1:0] cnt_r;
	wire [WIDTH-1:0] cnt_nxt;
	wire [WIDTH-1:0] cnt_inc;
	wire [WIDTH-1:0] mask;
	genvar i;
	// ----------------------------------------
	// Ratio mask: code n divides by two to the n plus one.
	// ----------------------------------------
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_mask
			assign mask[i] = (i <= ratio);
		end
	endgenerate
	assign cnt_inc = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
	assign cnt_nxt = cnt_inc & mask;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_r <= {WIDTH{1'b0}};
			tick_out <= 1'b0;
		end
		else if (bypass)
		begin
			// Bypass also clears the count so a new ratio starts clean.
			cnt_r <= {WIDTH{1'b0}};
			tick_out <= tick_in;
		end
		else
		begin
			tick_out <= 1'b0;
			if (tick_in)
			begin
				cnt_r <= cnt_nxt;
				tick_out <= (cnt_nxt == {WIDTH{1'b0}});
			end
		end
	end
endmodule

// ---- tdc_timer.v ----
// Ten-bit down counter with reload, one-shot, prescaler and PWM output.
// Assumes an AXI4-Lite master on aclk and asynchronous external clock pin.
//
// Overview of operation
// - Count register read returns live counter.
// - Count write loads reload and live counter.
// - Counter decrements only while run enable set.
// - Non-stop, reload set: underflow reloads stored value.
// - Non-stop, reload clear: underflow loads all ones.
// - One-shot counts once to zero then stops.
// - Non-stop mode keeps counting after underflow.
// - Polarity bit one makes PWM active low.
// - Pin enable routes PWM onto both pins.
// - Prescaler divides by two up to 256.
// - Disable bit high bypasses the prescaler.
// - Edge select picks falling or rising external edge.
// - Source bit selects external pin or internal clock.
// - Reload sets period, ten-bit duty sets width.
`include "tdc_defines.vh"
module tdc_timer (
	input wire aclk,
	input wire aresetn,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire inst_clk_en,
	input wire ext_clock_pin,
	input wire [1:0] gpio_out,
	output reg [1:0] pwm_pin_out,
	output reg counter_stopped
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [7:0] control_one_r;
	reg [5:0] control_two_r;
	reg [9:0] reload_r;
	reg [9:0] duty_r;
	reg [9:0] count_r;
	reg [9:0] count_nxt;
	reg done_r;
	reg [3:0] aw_addr_r;
	reg aw_have_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg w_have_r;
	reg ext_meta_r;
	reg ext_sync_r;
	reg ext_prev_r;
	wire run_enable = control_one_r[`TDC_C1_RUN];
	wire reload_select = control_one_r[`TDC_C1_RELOAD];
	wire one_shot_select = control_one_r[`TDC_C1_ONESHOT];
	wire pwm_active_low = control_one_r[`TDC_C1_ACTLOW];
	wire pwm_pin_enable = control_one_r[`TDC_C1_PINEN];
	wire [2:0] prescale_ratio = control_two_r[`TDC_C2_RATE_HI:`TDC_C2_RATE_LO];
	wire prescale_disable_n = control_two_r[`TDC_C2_PSDIS_N];
	wire ext_edge_select = control_two_r[`TDC_C2_EDGE];
	wire clock_source_select = control_two_r[`TDC_C2_SRC];
	wire [1:0] count_high_bits = control_two_r[`TDC_C2_HIGH_HI:`TDC_C2_HIGH_LO];
	// ----------------------------------------
	// External clock pin synchroniser and edge pick
	// ----------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end
		else
		begin
			ext_meta_r <= ext_clock_pin;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end
	// Pin edges faster than half of aclk are lost by the sampling.
	wire ext_rise = ext_sync_r & ~ext_prev_r;
	wire ext_fall = ~ext_sync_r & ext_prev_r;
	wire ext_tick = ext_edge_select ? ext_fall : ext_rise;
	wire src_tick = clock_source_select ? ext_tick : inst_clk_en;
	wire cnt_tick;
	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	// A ratio change while running may give one short period; software keeps it bypassed.
	tdc_prescaler #(
		.WIDTH(8)
	) u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(src_tick),
		.bypass(prescale_disable_n),
		.ratio(prescale_ratio),
		.tick_out(cnt_tick)
	);
	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
	wire wr_count = wr_fire & (aw_addr_r == `TDC_ADDR_COUNT) & w_strb_r[0];
	wire wr_ok = (aw_addr_r == `TDC_ADDR_COUNT) | (aw_addr_r == `TDC_ADDR_CTRL1) |
		(aw_addr_r == `TDC_ADDR_CTRL2) | (aw_addr_r == `TDC_ADDR_DUTY);
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TDC_RESP_OKAY;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			control_one_r <= `TDC_CTRL1_RST;
			control_two_r <= `TDC_CTRL2_RST;
			reload_r <= `TDC_ZERO_COUNT;
			duty_r <= `TDC_ZERO_COUNT;
		end
		else
		begin
			if (aw_take)
			begin
				aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
				aw_have_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take)
			begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				w_have_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `TDC_RESP_OKAY : `TDC_RESP_SLVERR;
				if (w_strb_r[0])
				begin
					case (aw_addr_r)
						`TDC_ADDR_COUNT: reload_r <= {count_high_bits, w_data_r[7:0]};
						`TDC_ADDR_CTRL1: control_one_r <= w_data_r[7:0];
						`TDC_ADDR_CTRL2: control_two_r <= w_data_r[5:0];
						`TDC_ADDR_DUTY: duty_r <= w_data_r[9:0];
						default: ;
					endcase
				end
				if ((aw_addr_r == `TDC_ADDR_DUTY) & w_strb_r[1])
					duty_r[`TDC_DUTY_HIGH_HI:`TDC_DUTY_HIGH_LO] <= w_data_r[9:8];
			end
			if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TDC_RESP_OKAY;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `TDC_RESP_OKAY;
			case ({s_axi_araddr[3:2], 2'b00})
				`TDC_ADDR_COUNT: s_axi_rdata <= {22'h00_0000, count_r};
				`TDC_ADDR_CTRL1: s_axi_rdata <= {24'h00_0000, control_one_r[7:6],
					3'b000, control_one_r[2:0]};
				`TDC_ADDR_CTRL2: s_axi_rdata <= {25'h000_0000, done_r, control_two_r};
				`TDC_ADDR_DUTY: s_axi_rdata <= {22'h00_0000, duty_r};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `TDC_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid & s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	// ----------------------------------------
	// Down counter
	// ----------------------------------------
	always @*
	begin
		count_nxt = count_r;
		if (count_r != `TDC_ZERO_COUNT)
			count_nxt = count_r - 10'h001;
		else if (!one_shot_select)
			count_nxt = reload_select ? reload_r : `TDC_FULL_COUNT;
	end
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_r <= `TDC_ZERO_COUNT;
			done_r <= 1'b0;
		end
		else if (wr_count)
		begin
			count_r <= {count_high_bits, w_data_r[7:0]};
			done_r <= 1'b0;
		end
		else if (run_enable & cnt_tick & ~done_r)
		begin
			count_r <= count_nxt;
			if (one_shot_select & (count_r == `TDC_ZERO_COUNT))
				done_r <= 1'b1;
		end
	end
	// ----------------------------------------
	// PWM output
	// ----------------------------------------
	// Duty above the reload value gives a fully active frame.
	wire pwm_active = (count_r < duty_r);
	wire pwm_level = pwm_active ^ pwm_active_low;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwm_pin_out <= 2'b00;
			counter_stopped <= 1'b0;
		end
		else
		begin
			pwm_pin_out <= pwm_pin_enable ? {2{pwm_level}} : gpio_out;
			counter_stopped <= done_r | ~run_enable;
		end
	end
endmodule

// ---- tdc_ext_src.sv ----
// Model of the external clock pin feeding the timer.
// Assumes the bench calls drive from its main sequence on aclk.
module tdc_ext_src (
	input wire aclk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin = 1'b0;
	// Each level is held long enough to cross the pin synchroniser.
	task drive(input logic v);
		@(posedge aclk);
		pin <= v;
		repeat (8) @(posedge aclk);
	endtask
endmodule

// ---- tdc_timer_asserts.sv ----
// Bus and pin checks for the timer, bound into its top module.
// Assumes one clock domain and a synchronous active-low reset.
module tdc_timer_asserts (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] gpio_out,
	input wire [1:0] pwm_pin_out
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_rst;
		disable iff (1'b0) !aresetn |=> s_axi_awready && s_axi_arready && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("bus busy in reset");
	property p_ar;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar: assert property (p_ar) else $error("late read data");
	property p_rh;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rh: assert property (p_rh) else $error("read data dropped");
	property p_re;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_re: assert property (p_re) else $error("read data repeated");
	property p_bh;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bh: assert property (p_bh) else $error("response dropped");
	property p_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("late response");
	property p_ab;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_ab: assert property (p_ab) else $error("write taken early");
	property p_io;
		pwm_pin_out[1] != pwm_pin_out[0] |-> pwm_pin_out == $past(gpio_out);
	endproperty
	a_io: assert property (p_io) else $error("pins not general");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (pwm_pin_out == 2'b01);
endmodule
bind tdc_timer tdc_timer_asserts tdc_timer_asserts_i (.*);

// ---- tdc_timer_tb.sv ----
// Self-checking bench for the timer over its AXI4-Lite register bus.
// Assumes the checker binds itself and the pin model makes ext edges.
module tdc_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, inst_clk_en = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, counter_stopped;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, gpio_out = 0, pwm_pin_out;
	wire ext_clock_pin;
	int n_errors = 0, checks = 0;
	always #20 aclk = ~aclk;
	tdc_timer tdc_timer_i (.*);
	tdc_ext_src tdc_ext_src_i (.aclk(aclk), .pin(ext_clock_pin));
	task summarize;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] g, e);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1 && n < 40);
		s_axi_bready <= 0;
		chk("bresp", s_axi_bresp, 2'b00);
		if (s_axi_bvalid !== 1) chk("wait", 1, 0);
		if (s_axi_bvalid !== 1) summarize;
	endtask
	task rd(input logic [3:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 0;
			rv = s_axi_rdata;
			rsp = s_axi_rresp;
		end while (s_axi_rvalid !== 1 && n < 40);
		s_axi_rready <= 0;
		if (s_axi_rvalid !== 1) chk("wait", 1, 0);
		if (s_axi_rvalid !== 1) summarize;
	endtask
	task rc(input logic [3:0] a, input logic [31:0] e);
		rd(a);
		chk("reg", rv, e);
	endtask
	// Internal ticks are spaced so each one is seen as its own pulse.
	task tk(input int k);
		repeat (k)
		begin
			@(posedge aclk);
			inst_clk_en <= 1;
			@(posedge aclk);
			inst_clk_en <= 0;
		end
		repeat (3) @(posedge aclk);
	endtask
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rc(0, 0);
		rc(8, 8'h3F);
		rd(2);
		chk("rresp", rsp, 2'b00);
		chk("reg", rv, 0);
		$display("reset done");
		wr(8, 8'h08);
		wr(0, 5);
		tk(3);
		rc(0, 5);
		chk("stop", counter_stopped, 1);
		wr(4, 1);
		tk(7);
		rc(0, 10'h3FE);
		wr(4, 3);
		wr(0, 5);
		tk(7);
		rc(0, 4);
		chk("stop", counter_stopped, 0);
		wr(4, 5);
		wr(0, 5);
		tk(8);
		rc(0, 0);
		chk("stop", counter_stopped, 1);
		$display("modes done");
		wr(4, 1);
		for (int r = 0; r < 8; r++)
		begin
			wr(8, 8 | r);
			wr(8, r);
			wr(0, 8'h10);
			tk(4 << r);
			rc(0, 8'h0E);
			wr(8, 8 | r);
		end
		$display("prescale done");
		wr(8, 8'h38);
		wr(0, 8'h10);
		tk(2);
		rc(0, 10'h310);
		tdc_ext_src_i.drive(1);
		rc(0, 10'h310);
		tdc_ext_src_i.drive(0);
		rc(0, 10'h30F);
		wr(8, 8'h28);
		tdc_ext_src_i.drive(1);
		rc(0, 10'h30E);
		tdc_ext_src_i.drive(0);
		rc(0, 10'h30E);
		$display("external done");
		wr(8, 8'h08);
		wr(0, 5);
		wr(4, 0);
		gpio_out <= 2'b01;
		rd(0);
		chk("pins", pwm_pin_out, 2'b01);
		for (int i = 0; i < 4; i++)
		begin
			wr(12, i[1] ? 10'h200 : 3);
			wr(4, i[0] ? 8'hC0 : 8'h80);
			rd(0);
			chk("pins", pwm_pin_out, {2{i[1] ^ i[0]}});
		end
		$display("pwm done");
		summarize;
	end
endmodule
